// File: psr_status_id.v
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.vh"

module psr_status_id (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Management pins
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe,
  input  wire [4:0]  dev_addr,
  // Link condition inputs
  input  wire        an_complete,
  input  wire        remote_fault_evt,
  input  wire        jabber_evt,
  input  wire        speed_10,
  input  wire        link_good
);

  // ========================================================
  // States
  localparam [5:0] ST_PRE  = 6'b000001;
  localparam [5:0] ST_IDLE = 6'b000010;
  localparam [5:0] ST_ST2  = 6'b000100;
  localparam [5:0] ST_HDR  = 6'b001000;
  localparam [5:0] ST_TA   = 6'b010000;
  localparam [5:0] ST_DATA = 6'b100000;

  reg  [5:0]  state;
  reg  [5:0]  pre_cnt;
  reg  [3:0]  cnt;
  reg  [10:0] hdr;
  reg         is_read;
  reg         hit;
  reg  [15:0] rd_shift;
  reg         mdc_q;
  reg         remote_fault;
  reg         link_latched;
  reg         jabber;
  reg         read_clear;

  wire        rise = mdc & ~mdc_q;
  wire [11:0] full_hdr = {hdr, mdio_in};

  // ========================================================
  // Register read decode
  function [15:0] reg_value;
    input [4:0] addr;
    input       an_c;
    input       rf;
    input       lk;
    input       jb;
    begin
      case (addr)
        `PSR_ADDR_STATUS: begin
          reg_value = {`PSR_STAT_T4,
                       `PSR_STAT_ABILITIES,
                       `PSR_STAT_RSVD,
                       `PSR_STAT_UNIDIR,
                       `PSR_STAT_NO_PRE,
                       an_c,
                       rf,
                       `PSR_STAT_AN_ABLE,
                       lk,
                       jb,
                       `PSR_STAT_EXTENDED};
        end
        `PSR_ADDR_ID_UPPER: begin
          reg_value = `PSR_ORG_ID_HIGH_BITS;
        end
        `PSR_ADDR_ID_LOWER: begin
          reg_value = {`PSR_ORG_ID_LOW_BITS,
                       `PSR_MODEL_NUMBER,
                       `PSR_MODEL_REVISION};
        end
        default: begin
          reg_value = 16'h0000;
        end
      endcase
    end
  endfunction

  // ========================================================
  // Latched flags; a new fault, jabber (only with speed_10 high) or link-down event wins over read clear
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      remote_fault <= `PSR_RST_REMOTE_FAULT;
      link_latched <= `PSR_RST_LINK;
      jabber       <= `PSR_RST_JABBER;
    end else begin
      remote_fault <= (remote_fault & ~read_clear) | remote_fault_evt;
      link_latched <= link_good & (link_latched | read_clear);
      jabber       <= (jabber & ~read_clear) | (jabber_evt & speed_10);
    end
  end

  // ========================================================
  // Management frame engine
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ST_PRE;
      pre_cnt    <= 6'h00;
      cnt        <= 4'h0;
      hdr        <= 11'h000;
      is_read    <= 1'b0;
      hit        <= 1'b0;
      rd_shift   <= 16'h0000;
      mdc_q      <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe    <= 1'b0;
      read_clear <= 1'b0;
    end else begin
      mdc_q      <= mdc;
      read_clear <= 1'b0;
      if (rise) begin
        case (state)
          // Full preamble needed after reset, a bad opcode or a bad write turnaround
          ST_PRE: begin
            if (!mdio_in) begin
              pre_cnt <= 6'h00;
            end else if (pre_cnt == `PSR_PREAMBLE_BITS - 6'h01) begin
              pre_cnt <= 6'h00;
              state   <= ST_IDLE;
            end else begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end
          // Preamble may be suppressed from here on
          ST_IDLE: begin
            if (!mdio_in) begin
              state <= ST_ST2;
            end
          end
          ST_ST2: begin
            cnt   <= 4'h0;
            state <= mdio_in ? ST_HDR : ST_IDLE;
          end
          ST_HDR: begin
            hdr <= full_hdr[10:0];
            if (cnt == `PSR_HDR_LAST) begin
              cnt     <= 4'h0;
              is_read <= (full_hdr[11:10] == `PSR_OP_READ);
              hit     <= (full_hdr[9:5] == dev_addr);
              if (full_hdr[11:10] == `PSR_OP_READ || full_hdr[11:10] == `PSR_OP_WRITE) begin
                state <= ST_TA;
              end else begin
                state <= ST_PRE;
              end
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          // Turnaround: device drives zero in second bit of a read
          ST_TA: begin
            if (cnt == 4'h0) begin
              cnt <= 4'h1;
              if (is_read) begin
                rd_shift   <= reg_value(hdr[4:0], an_complete, remote_fault,
                                        link_latched, jabber);
                read_clear <= hit & (hdr[4:0] == `PSR_ADDR_STATUS);
                mdio_out   <= 1'b0;
                mdio_oe    <= hit;
              end else if (!mdio_in) begin
                state <= ST_PRE;
              end
            end else begin
              cnt <= 4'h0;
              if (is_read) begin
                mdio_out <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
                state    <= ST_DATA;
              end else if (mdio_in) begin
                state <= ST_PRE;
              end else begin
                state <= ST_DATA;
              end
            end
          end
          // Data bits; writes are ignored, all bits read-only
          ST_DATA: begin
            if (cnt == `PSR_DATA_LAST) begin
              cnt      <= 4'h0;
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b0;
              state    <= ST_IDLE;
            end else begin
              cnt <= cnt + 4'h1;
              if (is_read) begin
                mdio_out <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
              end
            end
          end
          default: begin
            state   <= ST_PRE;
            mdio_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: psr_regs.vh
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// ==========================================================
// Register offsets
`define PSR_ADDR_STATUS      5'h01
`define PSR_ADDR_ID_UPPER    5'h02
`define PSR_ADDR_ID_LOWER    5'h03

// ==========================================================
// Status word fixed fields
`define PSR_STAT_T4          1'h0
`define PSR_STAT_ABILITIES   4'hf
`define PSR_STAT_RSVD        3'h0
`define PSR_STAT_UNIDIR      1'h1
`define PSR_STAT_NO_PRE      1'h1
`define PSR_STAT_AN_ABLE     1'h1
`define PSR_STAT_EXTENDED    1'h1

// Latched flag reset values
`define PSR_RST_REMOTE_FAULT 1'h0
`define PSR_RST_LINK         1'h0
`define PSR_RST_JABBER       1'h0

// ==========================================================
// Identifier values (arbitrary, neutral)
`define PSR_ORG_ID_HIGH_BITS 16'h1234
`define PSR_ORG_ID_LOW_BITS  6'h2a
`define PSR_MODEL_NUMBER     6'h05
`define PSR_MODEL_REVISION   4'h1

// ==========================================================
// Management frame fields and counts
`define PSR_PREAMBLE_BITS    6'h20
`define PSR_HDR_LAST         4'hb
`define PSR_DATA_LAST        4'hf
`define PSR_OP_READ          2'h2
`define PSR_OP_WRITE         2'h1

`endif

// File: psr_status_id_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.vh"
// ====
// Status word fields as seen on the wire
module psr_status_id_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Link condition
  input wire logic an_complete
);
  logic       mdc_q;
  logic       stat;
  logic [4:0] k;
  logic [5:0] hdr;
  wire        rise = mdc & ~mdc_q;
  wire        fld  = rise & mdio_oe & stat;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdc_q <= 1'b0;
      hdr   <= 6'h00;
      stat  <= 1'b0;
      k     <= 5'h00;
    end else begin
      mdc_q <= mdc;
      if (rise) hdr <= {hdr[4:0], mdio_in};
      if (!mdio_oe) begin
        stat <= (hdr[4:0] == `PSR_ADDR_STATUS);
        k    <= 5'h00;
      end else if (rise) k <= k + 5'h01;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_T4: assert property (fld && k == 5'h01 |-> !mdio_out) else $error("bit 15 set");
  AST_ABIL: assert property (fld && k >= 5'h02 && k <= 5'h05 |-> mdio_out) else $error("ability bit low");
  AST_RSVD: assert property (fld && k >= 5'h06 && k <= 5'h08 |-> !mdio_out) else $error("reserved set");
  AST_UNIDIR: assert property (fld && k == 5'h09 |-> mdio_out) else $error("bit 7 low");
  AST_NOPRE: assert property (fld && k == 5'h0a |-> mdio_out) else $error("bit 6 low");
  AST_AN: assert property (fld && k == 5'h0b |-> mdio_out == an_complete) else $error("bit 5 wrong");
  AST_ANABLE: assert property (fld && k == 5'h0d |-> mdio_out) else $error("bit 3 low");
  AST_EXT: assert property (fld && k == 5'h10 |-> mdio_out) else $error("bit 0 low");
  cover property (fld && k == 5'h10);
  cover property ($rose(mdio_oe));
  cover property (rise && mdio_oe && !stat);
endmodule
`default_nettype wire

// File: psr_smi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Station management controller
module psr_smi_host (
  // Clock
  input  wire logic sys_clk,
  // Management pins
  output var  logic mdc,
  output wire logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv = 1'b1;
  logic bv  = 1'b1;
  initial mdc = 1'b0;
  // Line pulled up when nobody drives
  assign mdio_in = drv ? bv : (mdio_oe ? mdio_out : 1'b1);
  task bitx(input logic b, input logic en, output logic w);
    begin
      drv <= en;
      bv  <= b;
      mdc <= 1'b0;
      repeat (2) @(posedge sys_clk);
      w = mdio_in;
      mdc <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task xfer(input logic p, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] rg,
            input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic        w;
    integer      i;
    begin
      f = {2'b01, op, pa, rg, 2'b10, wd};
      if (p) for (i = 0; i < 32; i = i + 1) bitx(1'b1, 1'b1, w);
      for (i = 31; i >= 0; i = i - 1) begin
        bitx(f[i], op != 2'h2 || i > 17, w);
        rd = {rd[14:0], w};
      end
    end
  endtask
endmodule
`default_nettype wire

// File: psr_status_id_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.vh"
module psr_status_id_bench;
  logic        sys_clk = 0, reset_n = 0, an_complete = 0, remote_fault_evt = 0;
  logic        jabber_evt = 0, speed_10 = 0, link_good = 0, rf_m = 0, jb_m = 0, lk_m = 0;
  wire         mdc, mdio_in, mdio_out, mdio_oe;
  integer      mismatches = 0, cmp_count = 0, tn = 0, i;
  logic [31:0] seed = 32'h11;
  logic [15:0] d;
  always #5 sys_clk = ~sys_clk;
  psr_status_id dut (.sys_clk(sys_clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .dev_addr(5'h01), .an_complete(an_complete),
    .remote_fault_evt(remote_fault_evt), .jabber_evt(jabber_evt), .speed_10(speed_10), .link_good(link_good));
  psr_smi_host host (.sys_clk(sys_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  function [31:0] xs(input [31:0] x);
    logic [31:0] y;
    begin
      y  = x ^ (x << 13);
      y  = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [15:0] st(input an, input rf, input lk, input jb);
    st = {1'h0, 4'hf, 3'h0, 2'h3, an, rf, 1'h1, lk, jb, 1'h1};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd(input logic p, input logic [4:0] pa, input logic [4:0] rg, input logic [15:0] exp);
    begin
      host.xfer(p, 2'h2, pa, rg, 16'h0000, d);
      chk(d, exp);
      tn = tn + 1;
      $display("test %0d done", tn);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #500000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(1, 5'h01, `PSR_ADDR_STATUS, st(0, 0, 0, 0));
    for (i = 0; i < 24; i = i + 1) begin
      repeat (8) begin
        @(posedge sys_clk);
        seed = xs(seed);
        remote_fault_evt <= seed[0] & seed[1];
        jabber_evt       <= seed[2] & seed[3];
        speed_10         <= seed[4];
        link_good        <= |seed[7:5];
        rf_m = rf_m | (seed[0] & seed[1]);
        jb_m = jb_m | (seed[2] & seed[3] & seed[4]);
        lk_m = lk_m & (|seed[7:5]);
      end
      @(posedge sys_clk);
      remote_fault_evt <= 1'b0;
      jabber_evt       <= 1'b0;
      link_good        <= seed[8];
      an_complete      <= seed[9];
      lk_m = lk_m & seed[8];
      repeat (3) @(posedge sys_clk);
      rd(0, 5'h01, `PSR_ADDR_STATUS, st(seed[9], rf_m, lk_m, jb_m));
      rf_m = 0;
      jb_m = 0;
      lk_m = seed[8];
    end
    rd(0, 5'h01, `PSR_ADDR_STATUS, st(seed[9], 0, seed[8], 0));
    rd(0, 5'h01, `PSR_ADDR_ID_UPPER, `PSR_ORG_ID_HIGH_BITS);
    rd(0, 5'h01, `PSR_ADDR_ID_LOWER, {`PSR_ORG_ID_LOW_BITS, `PSR_MODEL_NUMBER, `PSR_MODEL_REVISION});
    rd(0, 5'h01, 5'h04, 16'h0000);
    rd(0, 5'h07, `PSR_ADDR_STATUS, 16'hffff);
    host.xfer(0, 2'h1, 5'h01, `PSR_ADDR_STATUS, 16'h0000, d);
    rd(0, 5'h01, `PSR_ADDR_STATUS, st(seed[9], 0, seed[8], 0));
    host.xfer(0, 2'h3, 5'h01, `PSR_ADDR_STATUS, 16'h0000, d);
    rd(0, 5'h01, `PSR_ADDR_STATUS, 16'hffff);
    rd(1, 5'h01, `PSR_ADDR_STATUS, st(seed[9], 0, seed[8], 0));
    final_report;
  end
endmodule
bind psr_status_id psr_status_id_props u_props (.sys_clk, .reset_n, .mdc, .mdio_in, .mdio_out, .mdio_oe, .an_complete);
`default_nettype wire
